// ==== bench/sem_event_masks_properties.sv ====
`timescale 1ns/1ps
module sem_chk
	import sem_pkg::*;
(
	input wire logic        clk, rstn, wr_en, preset, meas_summary, ques_summary, oper_summary,
	input wire logic [1:0]  wr_sel,
	input wire logic [15:0] wr_data, meas_event, ques_event, oper_event,
	input wire sem_masks_t  masks
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire w = wr_en && !preset;
	property p_wm; w && wr_sel == 2'h0 |=> masks.meas == ($past(wr_data) & 16'h0238); endproperty
	a_wm: assert property (p_wm) else $error("meas mask");
	property p_wq; w && wr_sel == 2'h1 |=> masks.ques == ($past(wr_data) & 16'h0100); endproperty
	a_wq: assert property (p_wq) else $error("ques mask");
	property p_wo; w && wr_sel == 2'h2 |=> masks.oper == ($past(wr_data) & 16'h0078); endproperty
	a_wo: assert property (p_wo) else $error("oper mask");
	property p_pr; preset |=> masks == '0; endproperty
	a_pr: assert property (p_pr) else $error("preset");
	property p_hd; !preset && !(wr_en && wr_sel != 2'h3) |=> $stable(masks); endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_ms; 1 |=> meas_summary == |($past(meas_event) & $past(masks.meas)); endproperty
	a_ms: assert property (p_ms) else $error("meas sum");
	property p_qs; 1 |=> ques_summary == |($past(ques_event) & $past(masks.ques)); endproperty
	a_qs: assert property (p_qs) else $error("ques sum");
	property p_os; 1 |=> oper_summary == |($past(oper_event) & $past(masks.oper)); endproperty
	a_os: assert property (p_os) else $error("oper sum");
	c_pr: cover property (preset && wr_en);
	c_os: cover property (oper_summary);
	c_ms: cover property (meas_summary);
endmodule
bind sem_event_masks sem_chk u_chk(.clk(clk), .rstn(rstn), .wr_en(wr_en), .preset(preset), .wr_sel(wr_sel),
	.wr_data(wr_data), .meas_event(meas_event), .ques_event(ques_event), .oper_event(oper_event), .masks(masks),
	.meas_summary(meas_summary), .ques_summary(ques_summary), .oper_summary(oper_summary));

// ==== bench/sem_host.sv ====
`timescale 1ns/1ps
module sem_host(
	input wire logic   clk,
	output logic       wr_en, preset,
	output logic [1:0] wr_sel,
	output logic [15:0] wr_data
);
	initial {wr_en, preset, wr_sel, wr_data} = '0;
	// The decimal sum of weights arrives as its binary form; data is scrambled once released.
	task send(input logic p, input logic [1:0] s, input logic [15:0] v);
		@(negedge clk);
		{preset, wr_en, wr_sel, wr_data} = {p, 1'b1, s, v};
		@(negedge clk);
		{preset, wr_en, wr_data} = {2'b00, ~v};
	endtask
endmodule

// ==== bench/test_sem_event_masks.sv ====
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin failures++; $display("[ERR] %0t mismatch",$time); end end
module test_sem_event_masks;
	import sem_pkg::*;
	logic clk = 0, rstn = 0;
	logic [1:0] rd_sel = 0;
	logic [15:0] me = 0, qe = 0, oe = 0;
	wire wr_en, preset, ms, qs, os;
	wire [1:0] wr_sel;
	wire [15:0] wr_data, rd_data;
	sem_masks_t masks;
	int failures = 0, cmp_count = 0;
	logic [33:0] rows [6] = '{34'h0ffff0238, 34'h1ffff0100, 34'h1feff0000, 34'h000200020, 34'h200180018, 34'h2ffff0078};
	sem_host host(.clk(clk), .wr_en(wr_en), .preset(preset), .wr_sel(wr_sel), .wr_data(wr_data));
	sem_event_masks dut(.clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel),
		.rd_data(rd_data), .preset(preset), .meas_event(me), .ques_event(qe), .oper_event(oe), .meas_summary(ms),
		.ques_summary(qs), .oper_summary(os), .masks(masks));
	task stop_test;
		if (failures == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever #20 clk = ~clk;
	initial begin
		repeat (4) @(negedge clk);
		`CHK(masks, 48'h0)
		rstn = 1;
		foreach (rows[i]) begin
			host.send(1'b0, rows[i][33:32], rows[i][31:16]);
			rd_sel = rows[i][33:32];
			@(negedge clk);
			`CHK(rd_data, rows[i][15:0])
		end
		oe = 16'h0008;
		@(negedge clk);
		`CHK(os, 1'b1)
		{me, qe, oe} = {16'hffff, 16'hffff, 16'hff87};
		@(negedge clk);
		`CHK({ms, qs, os}, 3'b100)
		host.send(1'b1, 2'h2, 16'h0078);
		@(negedge clk);
		`CHK({masks, ms, os}, 50'h0)
		host.send(1'b0, 2'h3, 16'hffff);
		`CHK(masks, 48'h0)
		host.send(1'b0, 2'h1, 16'h0100);
		rd_sel = 2'h3;
		@(negedge clk);
		`CHK(qs, 1'b1)
		`CHK(rd_data, 16'h0000)
		rstn = 0;
		@(negedge clk);
		`CHK({masks, qs}, 49'h0)
		rstn = 1;
		@(negedge clk);
		@(negedge clk);
		`CHK(qs, 1'b0)
		stop_test;
	end
endmodule

// ==== hdl/sem_event_masks.sv ====
`timescale 1ns/1ps
`include "sem_params.svh"
// How it works
// - Each event register has a bitwise mask.
// - Zero mask bit blocks event from summary.
// - One mask bit lets event join summary.
// - Unmasked set event raises next summary bit.
// - Mask bits load from written value's bits.
// - Measurement mask bits 9,5,4,3 defined.
// - Questionable mask only bit 8 defined.
// - Operation supply bit 6, heatsink bit 5.
// - Operation limit-tripped bit 4, limiting bit 3.
// - Preset clears all three masks, nothing else.
module sem_event_masks
	import sem_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// Mask write and read-back from the command parser.
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_sel,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  rd_sel,
	output logic      [15:0] rd_data,
	input  wire logic        preset,
	// Event registers and summaries.
	input  wire logic [15:0] meas_event,
	input  wire logic [15:0] ques_event,
	input  wire logic [15:0] oper_event,
	output logic             meas_summary,
	output logic             ques_summary,
	output logic             oper_summary,
	output sem_masks_t       masks
);

	// Only defined bits own a flip-flop, so reserved bits read zero by construction.
	logic        buffer_full_en_ff;
	logic        nxt_buffer_full_en;
	logic        reading_ready_en_ff;
	logic        nxt_reading_ready_en;
	logic        pulse_trigger_timeout_en_ff;
	logic        nxt_pulse_trigger_timeout_en;
	logic        reading_overflow_en_ff;
	logic        nxt_reading_overflow_en;
	logic        cal_summary_en_ff;
	logic        nxt_cal_summary_en;
	logic        supply_shutdown_en_ff;
	logic        nxt_supply_shutdown_en;
	logic        heatsink_shutdown_en_ff;
	logic        nxt_heatsink_shutdown_en;
	logic        current_limit_tripped_en_ff;
	logic        nxt_current_limit_tripped_en;
	logic        current_limiting_en_ff;
	logic        nxt_current_limiting_en;

	// Read-back and summary state.
	logic [15:0] rd_ff;
	logic [15:0] nxt_rd;
	logic        meas_sum_ff;
	logic        nxt_meas_sum;
	logic        ques_sum_ff;
	logic        nxt_ques_sum;
	logic        oper_sum_ff;
	logic        nxt_oper_sum;

	// Assembled mask words and per-register views, indexed 0 meas, 1 ques, 2 oper.
	sem_masks_t  mask_view;
	logic [2:0]  wr_hit;
	logic [2:0]  rd_hit;
	wire  [15:0] ev_vec  [3];
	wire  [15:0] mk_vec  [3];
	wire  [15:0] hit_vec [3];

	// Decode of which defined bits a selected register owns.
	function automatic logic [15:0] defined_bits(input logic [1:0] sel);
		logic [15:0] d;
		d = 16'h0000;
		if (sel == `SEM_SEL_MEAS) begin
			d[`SEM_BIT_BUFFER_FULL]        = 1'b1;
			d[`SEM_BIT_READING_READY]      = 1'b1;
			d[`SEM_BIT_PULSE_TRIG_TIMEOUT] = 1'b1;
			d[`SEM_BIT_READING_OVERFLOW]   = 1'b1;
		end else if (sel == `SEM_SEL_QUES) begin
			d[`SEM_BIT_CAL_SUMMARY]        = 1'b1;
		end else if (sel == `SEM_SEL_OPER) begin
			d[`SEM_BIT_SUPPLY_SHUTDOWN]    = 1'b1;
			d[`SEM_BIT_HEATSINK_SHUTDOWN]  = 1'b1;
			d[`SEM_BIT_CURR_LIMIT_TRIPPED] = 1'b1;
			d[`SEM_BIT_CURRENT_LIMITING]   = 1'b1;
		end
		return d;
	endfunction

	// One-hot decode of a select code; code 3 selects nothing.
	function automatic logic [2:0] sel_onehot(input logic [1:0] sel);
		logic [2:0] h;
		h = 3'h0;
		if (sel == `SEM_SEL_MEAS) begin
			h = 3'h1;
		end else if (sel == `SEM_SEL_QUES) begin
			h = 3'h2;
		end else if (sel == `SEM_SEL_OPER) begin
			h = 3'h4;
		end
		return h;
	endfunction

	// Write strobes and read selects share one decode.
	assign wr_hit    = wr_en ? sel_onehot(wr_sel) : 3'h0;
	assign rd_hit    = sel_onehot(rd_sel);
	// Flatten the struct so one loop serves all three registers.
	assign ev_vec[0] = meas_event;
	assign ev_vec[1] = ques_event;
	assign ev_vec[2] = oper_event;
	assign mk_vec[0] = mask_view.meas;
	assign mk_vec[1] = mask_view.ques;
	assign mk_vec[2] = mask_view.oper;

	// Measurement mask group. Preset beats a simultaneous write so the masks end up known-clear.
	always_comb begin
		nxt_buffer_full_en           = buffer_full_en_ff;
		nxt_reading_ready_en         = reading_ready_en_ff;
		nxt_pulse_trigger_timeout_en = pulse_trigger_timeout_en_ff;
		nxt_reading_overflow_en      = reading_overflow_en_ff;
		if (preset) begin
			nxt_buffer_full_en           = 1'b0;
			nxt_reading_ready_en         = 1'b0;
			nxt_pulse_trigger_timeout_en = 1'b0;
			nxt_reading_overflow_en      = 1'b0;
		end else if (wr_hit[0]) begin
			// The parser has already turned the decimal sum into binary.
			nxt_buffer_full_en           = wr_data[`SEM_BIT_BUFFER_FULL];
			nxt_reading_ready_en         = wr_data[`SEM_BIT_READING_READY];
			nxt_pulse_trigger_timeout_en = wr_data[`SEM_BIT_PULSE_TRIG_TIMEOUT];
			nxt_reading_overflow_en      = wr_data[`SEM_BIT_READING_OVERFLOW];
		end
	end

	// Masks come out of reset cleared, the same state that a preset leaves.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buffer_full_en_ff           <= 1'b0;
			reading_ready_en_ff         <= 1'b0;
			pulse_trigger_timeout_en_ff <= 1'b0;
			reading_overflow_en_ff      <= 1'b0;
		end else begin
			buffer_full_en_ff           <= nxt_buffer_full_en;
			reading_ready_en_ff         <= nxt_reading_ready_en;
			pulse_trigger_timeout_en_ff <= nxt_pulse_trigger_timeout_en;
			reading_overflow_en_ff      <= nxt_reading_overflow_en;
		end
	end

	// Questionable mask group.
	always_comb begin
		nxt_cal_summary_en = cal_summary_en_ff;
		if (preset) begin
			// Preset wins over a write here too.
			nxt_cal_summary_en = 1'b0;
		end else if (wr_hit[1]) begin
			nxt_cal_summary_en = wr_data[`SEM_BIT_CAL_SUMMARY];
		end
	end

	// Reset clears the questionable mask as well.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cal_summary_en_ff <= 1'b0;
		end else begin
			cal_summary_en_ff <= nxt_cal_summary_en;
		end
	end

	// Operation mask group.
	always_comb begin
		nxt_supply_shutdown_en       = supply_shutdown_en_ff;
		nxt_heatsink_shutdown_en     = heatsink_shutdown_en_ff;
		nxt_current_limit_tripped_en = current_limit_tripped_en_ff;
		nxt_current_limiting_en      = current_limiting_en_ff;
		if (preset) begin
			// Preset wins over a write here too.
			nxt_supply_shutdown_en       = 1'b0;
			nxt_heatsink_shutdown_en     = 1'b0;
			nxt_current_limit_tripped_en = 1'b0;
			nxt_current_limiting_en      = 1'b0;
		end else if (wr_hit[2]) begin
			nxt_supply_shutdown_en       = wr_data[`SEM_BIT_SUPPLY_SHUTDOWN];
			nxt_heatsink_shutdown_en     = wr_data[`SEM_BIT_HEATSINK_SHUTDOWN];
			nxt_current_limit_tripped_en = wr_data[`SEM_BIT_CURR_LIMIT_TRIPPED];
			nxt_current_limiting_en      = wr_data[`SEM_BIT_CURRENT_LIMITING];
		end
	end

	// Reset clears the operation mask as well.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			supply_shutdown_en_ff       <= 1'b0;
			heatsink_shutdown_en_ff     <= 1'b0;
			current_limit_tripped_en_ff <= 1'b0;
			current_limiting_en_ff      <= 1'b0;
		end else begin
			supply_shutdown_en_ff       <= nxt_supply_shutdown_en;
			heatsink_shutdown_en_ff     <= nxt_heatsink_shutdown_en;
			current_limit_tripped_en_ff <= nxt_current_limit_tripped_en;
			current_limiting_en_ff      <= nxt_current_limiting_en;
		end
	end

	// Reserved positions stay at the cleared value on read-back and in the summary.
	// Write data for reserved positions is dropped because no flip-flop takes it.
	always_comb begin
		mask_view                                  = {3{`SEM_MASK_RESET}};
		mask_view.meas[`SEM_BIT_BUFFER_FULL]        = buffer_full_en_ff;
		mask_view.meas[`SEM_BIT_READING_READY]      = reading_ready_en_ff;
		mask_view.meas[`SEM_BIT_PULSE_TRIG_TIMEOUT] = pulse_trigger_timeout_en_ff;
		mask_view.meas[`SEM_BIT_READING_OVERFLOW]   = reading_overflow_en_ff;
		mask_view.ques[`SEM_BIT_CAL_SUMMARY]        = cal_summary_en_ff;
		mask_view.oper[`SEM_BIT_SUPPLY_SHUTDOWN]    = supply_shutdown_en_ff;
		mask_view.oper[`SEM_BIT_HEATSINK_SHUTDOWN]  = heatsink_shutdown_en_ff;
		mask_view.oper[`SEM_BIT_CURR_LIMIT_TRIPPED] = current_limit_tripped_en_ff;
		mask_view.oper[`SEM_BIT_CURRENT_LIMITING]   = current_limiting_en_ff;
	end

	// Masking is one AND gate per event bit; a zero mask bit blocks the event.
	// A reserved bit has no mask flip-flop and so can never reach a summary.
	for (genvar r = 0; r < 3; r++) begin : g_reg
		for (genvar b = 0; b < `SEM_W; b++) begin : g_bit
			assign hit_vec[r][b] = ev_vec[r][b] & mk_vec[r][b];
		end
	end

	// Summaries are levels, registered once so they never glitch on a mask write.
	// They use the stored masks, so a new mask affects them one clock after the write.
	always_comb begin
		nxt_meas_sum = |hit_vec[0];
		nxt_ques_sum = |hit_vec[1];
		nxt_oper_sum = |hit_vec[2];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meas_sum_ff <= 1'b0;
			ques_sum_ff <= 1'b0;
			oper_sum_ff <= 1'b0;
		end else begin
			meas_sum_ff <= nxt_meas_sum;
			ques_sum_ff <= nxt_ques_sum;
			oper_sum_ff <= nxt_oper_sum;
		end
	end

	// Read-back group. The selected word is registered, so it shows one clock after rd_sel.
	// Code 3 selects no register and reads zero.
	always_comb begin
		nxt_rd = 16'h0000;
		for (int r = 0; r < 3; r++) begin
			if (rd_hit[r]) begin
				nxt_rd = mk_vec[r] & defined_bits(2'(r));
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ff <= 16'h0000;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	// Outputs come straight from flip-flops, except reserved bits of masks, which are tied to zero.
	assign rd_data      = rd_ff;
	assign meas_summary = meas_sum_ff;
	assign ques_summary = ques_sum_ff;
	assign oper_summary = oper_sum_ff;
	assign masks        = mask_view;

endmodule

// ==== hdl/sem_params.svh ====
`ifndef SEM_PARAMS_SVH
`define SEM_PARAMS_SVH

`define SEM_W              16
`define SEM_SEL_MEAS       2'h0
`define SEM_SEL_QUES       2'h1
`define SEM_SEL_OPER       2'h2
`define SEM_BIT_BUFFER_FULL        9
`define SEM_BIT_READING_READY      5
`define SEM_BIT_PULSE_TRIG_TIMEOUT 4
`define SEM_BIT_READING_OVERFLOW   3
`define SEM_BIT_CAL_SUMMARY        8
`define SEM_BIT_SUPPLY_SHUTDOWN    6
`define SEM_BIT_HEATSINK_SHUTDOWN  5
`define SEM_BIT_CURR_LIMIT_TRIPPED 4
`define SEM_BIT_CURRENT_LIMITING   3
`define SEM_MEAS_DEFINED   16'h0238
`define SEM_QUES_DEFINED   16'h0100
`define SEM_OPER_DEFINED   16'h0078
`define SEM_MASK_RESET     16'h0000

`endif

// ==== hdl/sem_pkg.sv ====
package sem_pkg;
	typedef enum logic [1:0] {
		SEM_MEAS,
		SEM_QUES,
		SEM_OPER,
		SEM_NONE
	} sem_sel_t;

	typedef struct packed {
		logic [15:0] meas;
		logic [15:0] ques;
		logic [15:0] oper;
	} sem_masks_t;
endpackage
